// [verilog/watchdog_map.vh]
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH

// ==========================================================
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_RELOAD 12'h004
`define OFS_FEED 12'h008
`define OFS_COUNT 12'h00C
`define OFS_STATUS 12'h010
`define OFS_MASK 12'h014
`define OFS_AUX 12'h018

// ==========================================================
// Control register fields
`define CTRL_RUN 0
`define CTRL_RST_EN 1
`define CTRL_CLK_SEL 2
`define CTRL_TAP_LO 4
`define CTRL_TAP_HI 6
`define CTRL_W 7
`define CTRL_RESET 7'h06

// Auxiliary register field
`define AUX_SW_RESET 0

// Status and mask fields
`define ST_TIMEOUT 0
`define ST_FEED_ERR 1
`define ST_W 2

// ==========================================================
// Widths, reset values, feed bytes
`define PRE_W 12
`define CNT_W 8
`define RELOAD_RESET 8'hFF
`define TAP_BASE 4
`define FEED_FIRST 8'hA5
`define FEED_SECOND 8'h5A
`define OSC_NOMINAL_HZ 400000

`endif

// [verilog/watchdog_and_soft_reset.v]
`timescale 1ns/10ps
`include "watchdog_map.vh"

module watchdog_and_soft_reset (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  input wire wd_osc_clk,
  input wire power_down,
  output wire wdt_reset,
  output wire sw_reset,
  output wire sys_reset,
  output wire irq
);

  // ==========================================================
  // State
  reg [`CTRL_W-1:0] ctrl_ff;
  reg [`CTRL_W-1:0] pend_ctrl_ff;
  reg [`CNT_W-1:0] reload_ff;
  reg [`PRE_W-1:0] pre_ff;
  reg [`CNT_W-1:0] cnt_ff;
  reg [`ST_W-1:0] status_ff;
  reg [`ST_W-1:0] mask_ff;
  reg feed_half_ff;
  reg ctrl_armed_ff;
  reg osc_prev_ff;
  reg wdt_reset_ff;
  reg sw_reset_ff;
  reg [31:0] prdata_ff;
  reg pslverr_ff;

  reg [`CTRL_W-1:0] nxt_ctrl;
  reg [`CTRL_W-1:0] nxt_pend_ctrl;
  reg [`PRE_W-1:0] nxt_pre;
  reg [`CNT_W-1:0] nxt_cnt;
  reg [`ST_W-1:0] nxt_status;
  reg nxt_feed_half;
  reg nxt_ctrl_armed;
  reg nxt_wdt_reset;
  reg nxt_sw_reset;
  reg fault;
  reg feed_ok;
  reg feed_bad;

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;

  // ==========================================================
  // Register strobes
  // Decoded once so that the write, clear and pulse paths agree
  wire wr_reload = wr & (paddr == `OFS_RELOAD);
  wire wr_mask = wr & (paddr == `OFS_MASK);
  wire wr_aux = wr & (paddr == `OFS_AUX);
  wire rd_status = rd & (paddr == `OFS_STATUS);

  // ==========================================================
  // Address decode for the error answer only; the read mux decodes on its own
  function is_mapped;
    input [11:0] a;
    begin
      case (a)
        `OFS_CTRL, `OFS_RELOAD, `OFS_FEED, `OFS_COUNT,
        `OFS_STATUS, `OFS_MASK, `OFS_AUX: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Prescaler tap hit: all bits up to the selected tap are ones
  function tap_hit;
    input [`PRE_W-1:0] pre;
    input [2:0] sel;
    integer i;
    reg hit;
    begin
      hit = 1'b1;
      for (i = 0; i < `PRE_W; i = i + 1) begin
        if (i <= `TAP_BASE + sel) begin
          hit = hit & pre[i];
        end
      end
      tap_hit = hit;
    end
  endfunction

  // ==========================================================
  // Clock source and stepping
  wire run = ctrl_ff[`CTRL_RUN];
  wire rst_mode = ctrl_ff[`CTRL_RST_EN];
  wire osc_sel = ctrl_ff[`CTRL_CLK_SEL];
  wire [2:0] tap_sel = ctrl_ff[`CTRL_TAP_HI:`CTRL_TAP_LO];
  // source select; the oscillator is sampled and edge detected
  wire osc_tick = wd_osc_clk & ~osc_prev_ff;
  wire src_tick = osc_sel ? osc_tick : 1'b1;
  // An oscillator source keeps counting through power-down; a pclk
  // source is stopped, since pclk itself is gated there.
  // stop on power-down with the pclk source
  wire halted = ~run | (power_down & ~osc_sel);
  wire pre_tick = ~halted & src_tick;
  wire dec_pulse = pre_tick & tap_hit(pre_ff, tap_sel);
  wire underflow = dec_pulse & (cnt_ff == {`CNT_W{1'b0}});

  // ==========================================================
  // Next-state logic
  always @* begin
    nxt_ctrl = ctrl_ff;
    nxt_pend_ctrl = pend_ctrl_ff;
    nxt_pre = pre_ff;
    nxt_cnt = cnt_ff;
    nxt_status = status_ff;
    nxt_feed_half = feed_half_ff;
    nxt_ctrl_armed = ctrl_armed_ff;
    nxt_sw_reset = 1'b0;
    fault = 1'b0;
    feed_ok = 1'b0;
    feed_bad = 1'b0;

    if (pre_tick) begin
      nxt_pre = pre_ff + {{(`PRE_W-1){1'b0}}, 1'b1};
    end
    if (dec_pulse) begin
      nxt_cnt = cnt_ff - {{(`CNT_W-1){1'b0}}, 1'b1};
    end
    if (underflow) begin
      nxt_cnt = reload_ff;
      nxt_pre = {`PRE_W{1'b0}};
      if (rst_mode) begin
        fault = 1'b1;
      end else begin
        nxt_status[`ST_TIMEOUT] = 1'b1;
      end
    end

    // Read of status clears it; a new event in the same cycle wins
    if (rd_status) begin
      nxt_status = {`ST_W{1'b0}};
      if (underflow && !rst_mode) begin
        nxt_status[`ST_TIMEOUT] = 1'b1;
      end
    end

    // Reads never touch the feed sequence, so a status poll between the
    // two feed bytes is harmless.
    if (wr) begin
      case (paddr)
        `OFS_FEED: begin
          if (!feed_half_ff && pwdata[7:0] == `FEED_FIRST) begin
            nxt_feed_half = 1'b1;
          end else if (feed_half_ff && pwdata[7:0] == `FEED_SECOND) begin
            nxt_feed_half = 1'b0;
            feed_ok = 1'b1;
          end else begin
            nxt_feed_half = 1'b0;
            feed_bad = 1'b1;
          end
        end
        `OFS_CTRL: begin
          // held pending until the next valid feed
          nxt_pend_ctrl = pwdata[`CTRL_W-1:0];
          nxt_ctrl_armed = 1'b1;
          if (feed_half_ff) begin
            feed_bad = 1'b1;
          end
          nxt_feed_half = 1'b0;
        end
        default: begin
          if (feed_half_ff) begin
            feed_bad = 1'b1;
          end
          nxt_feed_half = 1'b0;
          // control write not followed by a feed
          if (ctrl_armed_ff) begin
            feed_bad = 1'b1;
          end
        end
      endcase
    end

    if (feed_ok) begin
      nxt_cnt = reload_ff;
      nxt_pre = {`PRE_W{1'b0}};
      // A setting dropped by a bad sequence stays unapplied
      if (ctrl_armed_ff) begin
        nxt_ctrl = pend_ctrl_ff;
      end
      nxt_ctrl_armed = 1'b0;
    end

    // A bad feed never reloads the counter: in watchdog mode the system reset restarts
    // software, and its next valid feed reloads.
    if (feed_bad) begin
      nxt_ctrl_armed = 1'b0;
      // bad sequence resets in watchdog mode
      if (rst_mode) begin
        fault = 1'b1;
      end else begin
        nxt_status[`ST_FEED_ERR] = 1'b1;
      end
    end

    if (wr_aux && pwdata[`AUX_SW_RESET]) begin
      nxt_sw_reset = 1'b1;
    end

    // Underflow and a bad feed in one cycle still give one pulse
    nxt_wdt_reset = fault;
  end

  // ==========================================================
  // Counter chain and sequence state
  // power-on reset only
  // The reset pulses below feed the system reset, but not this block:
  // clearing here would let a hung program restart with the watchdog off.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CTRL_RESET;
      pend_ctrl_ff <= `CTRL_RESET;
      pre_ff <= {`PRE_W{1'b0}};
      cnt_ff <= `RELOAD_RESET;
      status_ff <= {`ST_W{1'b0}};
      feed_half_ff <= 1'b0;
      ctrl_armed_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      pend_ctrl_ff <= nxt_pend_ctrl;
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      status_ff <= nxt_status;
      feed_half_ff <= nxt_feed_half;
      ctrl_armed_ff <= nxt_ctrl_armed;
    end
  end

  // ==========================================================
  // Software written settings, taken at the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_ff <= `RELOAD_RESET;
      mask_ff <= {`ST_W{1'b0}};
    end else begin
      if (wr_reload) begin
        reload_ff <= pwdata[`CNT_W-1:0];
      end
      if (wr_mask) begin
        mask_ff <= pwdata[`ST_W-1:0];
      end
    end
  end

  // ==========================================================
  // Oscillator edge detect
  // One stage only: the oscillator is treated as synchronous to pclk,
  // so a tick is lost if the oscillator ever runs faster than pclk / 2.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_ff <= 1'b0;
    end else begin
      osc_prev_ff <= wd_osc_clk;
    end
  end

  // ==========================================================
  // Reset request pulses, one pclk cycle each
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_reset_ff <= 1'b0;
      sw_reset_ff <= 1'b0;
    end else begin
      wdt_reset_ff <= nxt_wdt_reset;
      sw_reset_ff <= nxt_sw_reset;
    end
  end

  // ==========================================================
  // APB read path, captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      pslverr_ff <= ~is_mapped(paddr);
      case (paddr)
        `OFS_CTRL: prdata_ff <= {{(32-`CTRL_W){1'b0}}, ctrl_ff};
        `OFS_RELOAD: prdata_ff <= {{(32-`CNT_W){1'b0}}, reload_ff};
        `OFS_COUNT: prdata_ff <= {{(32-`CNT_W){1'b0}}, cnt_ff};
        `OFS_STATUS: prdata_ff <= {{(32-`ST_W){1'b0}}, status_ff};
        `OFS_MASK: prdata_ff <= {{(32-`ST_W){1'b0}}, mask_ff};
        // Unmapped and write-only offsets read as zero
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Status may change between setup and access; the value seen is the
  // one at setup, and the clear at access drops an event set at the setup edge unread.
  assign pready = access;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & access;

  // ==========================================================
  // Reset and interrupt outputs
  assign wdt_reset = wdt_reset_ff;
  assign sw_reset = sw_reset_ff;
  assign sys_reset = wdt_reset_ff | sw_reset_ff;
  // Level output; it drops only on a status read or a mask write
  assign irq = |(status_ff & mask_ff);

endmodule

// [tb/watchdog_and_soft_reset_props.sv]
`timescale 1ns/10ps
`include "watchdog_map.vh"
module wd_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire wd_osc_clk,
  input wire power_down,
  input wire wdt_reset,
  input wire sw_reset,
  input wire sys_reset,
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire sw_wr = wr && paddr == `OFS_AUX && pwdata[0];
  // =====
  // Feed steps
  sequence feed_a;
    wr && paddr == `OFS_FEED && pwdata[7:0] == `FEED_FIRST;
  endsequence
  sequence feed_b;
    wr && paddr == `OFS_FEED && pwdata[7:0] == `FEED_SECOND;
  endsequence
  feed_good_a:
    assert property (feed_a ##2 feed_b |=> !wdt_reset) else $error("feed");
  sw_pulse_a:
    assert property (sw_wr |=> sw_reset) else $error("sw reset");
  sw_cause_a:
    assert property (sw_reset |-> $past(sw_wr)) else $error("sw cause");
  wdt_single_a:
    assert property (wdt_reset |=> !wdt_reset) else $error("wdt pulse");
  sys_or_a:
    assert property (sys_reset == (wdt_reset || sw_reset)) else $error("sys");
  irq_sticky_a:
    assert property ($fell(irq) |-> $past(acc)) else $error("irq fell");
  unmapped_a:
    assert property (acc && !pwrite && paddr > `OFS_AUX |-> pslverr &&
      prdata == 32'h0000_0000) else $error("unmapped");
  pready_a:
    assert property (pready == acc) else $error("pready");
endmodule
bind watchdog_and_soft_reset wd_props wd_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .wd_osc_clk(wd_osc_clk),
  .power_down(power_down), .wdt_reset(wdt_reset), .sw_reset(sw_reset),
  .sys_reset(sys_reset), .irq(irq));

// [tb/watchdog_and_soft_reset_bench.sv]
`timescale 1ns/10ps
`include "watchdog_map.vh"
module watchdog_and_soft_reset_bench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg wd_osc_clk = 0, power_down = 0, se = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd = 0, seed = 32'h87e6_f6cc;
  wire pready, pslverr, wdt_reset, sw_reset, sys_reset, irq;
  wire [31:0] prdata;
  integer fail_count = 0, checked = 0, cyc = 0, wdt_n = 0, sw_n = 0;
  integer k, t, p, r, m, sys_n = 0;
  watchdog_and_soft_reset watchdog_and_soft_reset_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .wd_osc_clk(wd_osc_clk),
    .power_down(power_down), .wdt_reset(wdt_reset), .sw_reset(sw_reset),
    .sys_reset(sys_reset), .irq(irq));
  always #12.5 pclk = ~pclk;
  // =====
  // Pulse counters, oscillator stand-in, hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    wd_osc_clk <= ~wd_osc_clk;
    if (wdt_reset === 1'b1) wdt_n <= wdt_n + 1;
    if (sw_reset === 1'b1) sw_n <= sw_n + 1;
    if (sys_reset === 1'b1) sys_n <= sys_n + 1;
    if (cyc == 24000) begin
      fail_count = fail_count + 1;
      print_verdict;
    end
  end
  task print_verdict;
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function integer rnd(input integer lim);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed % lim;
  endfunction
  // Request held until pready; caller idles or starts the next setup
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task feed;
    apb(1, `OFS_FEED, `FEED_FIRST);
    apb(1, `OFS_FEED, `FEED_SECOND);
  endtask
  // Bounded wait for irq (s=1) or a new watchdog pulse (s=0)
  task ev(input s, input integer n);
    psel <= 0;
    penable <= 0;
    k = wdt_n;
    t = 0;
    do begin
      @(posedge pclk);
      t = t + 1;
    end while ((s ? irq !== 1'b1 : wdt_n == k) && t < n);
  endtask
  task bad(input [11:0] a1, input [31:0] d1, input [11:0] a2,
    input [31:0] d2);
    m = wdt_n;
    apb(1, a1, d1);
    apb(1, a2, d2);
    ev(0, 4);
    chk(wdt_n, m + 1);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdc(`OFS_CTRL, `CTRL_RESET);
    rdc(`OFS_RELOAD, `RELOAD_RESET);
    rdc(`OFS_COUNT, 32'h0000_00ff);
    apb(0, 12'h01c, 0);
    chk(se, 1);
    repeat (3) begin
      r = rnd(16);
      p = rnd(6);
      apb(1, `OFS_RELOAD, r);
      apb(1, `OFS_CTRL, 3 | (p % 2) << 2 | (p / 2) << 4);
      feed;
      rdc(`OFS_COUNT, r);
      p = ((r + 1) << (5 + p / 2)) * (1 + p % 2);
      ev(0, p + 10);
      chk(t > p - 8 && t < p + 10, 1);
      chk(wdt_n, k + 1);
    end
    rdc(`OFS_RELOAD, r);
    apb(1, `OFS_RELOAD, 32'h0000_00ff);
    apb(1, `OFS_CTRL, 32'h0000_0073);
    feed;
    bad(`OFS_FEED, `FEED_FIRST, `OFS_FEED, 0);
    bad(`OFS_MASK, 0, `OFS_FEED, `FEED_SECOND);
    bad(`OFS_CTRL, 3, `OFS_MASK, 0);
    m = sw_n;
    apb(1, `OFS_AUX, 1);
    rdc(`OFS_RELOAD, 32'h0000_00ff);
    chk(sw_n, m + 1);
    ev(0, 4100);
    rdc(`OFS_COUNT, 32'h0000_00fe);
    apb(1, `OFS_RELOAD, 3);
    apb(1, `OFS_MASK, 3);
    apb(1, `OFS_CTRL, 1);
    feed;
    m = wdt_n;
    ev(1, 140);
    chk(irq, 1);
    rdc(`OFS_STATUS, 1);
    ev(1, 1);
    chk(irq, 0);
    ev(1, 140);
    chk(irq, 1);
    chk(wdt_n, m);
    apb(1, `OFS_FEED, 0);
    apb(0, `OFS_STATUS, 0);
    chk(rd[1], 1);
    power_down <= 1;
    apb(0, `OFS_STATUS, 0);
    ev(1, 400);
    chk(irq, 0);
    apb(1, `OFS_CTRL, 5);
    feed;
    ev(1, 300);
    chk(irq, 1);
    chk(sys_n, wdt_n + sw_n);
    print_verdict;
  end
endmodule
